// File: shared/cfg_iack_pkg.sv
package cfg_iack_pkg;

    // ************************************************************
    // Register selects on the processor_bus slave port.
    // ************************************************************
    localparam logic [1:0] REG_SEL_CONFIG_ADDRESS = 2'h0;
    localparam logic [1:0] REG_SEL_CONFIG_DATA = 2'h1;
    localparam logic [1:0] REG_SEL_IACK_GENERATOR = 2'h2;
    localparam logic [1:0] REG_SEL_MISC_CONTROL = 2'h3;

    // ************************************************************
    // Field layout of config_cycle_address.
    // ************************************************************
    localparam int CFG_TYPE_BIT = 0;
    localparam int CFG_REG_LSB = 2;
    localparam int CFG_REG_MSB = 7;
    localparam int CFG_FUNC_LSB = 8;
    localparam int CFG_FUNC_MSB = 10;
    localparam int CFG_DEV_LSB = 11;
    localparam int CFG_DEV_MSB = 14;
    localparam int CFG_BUS_LSB = 16;
    localparam int CFG_BUS_MSB = 23;
    localparam logic [31:0] CFG_ADDR_WRITE_MASK = 32'h00ff7ffd;

    // Type 0 cycles place one-hot device selects from this bit up.
    localparam int IDSEL_BASE_BIT = 16;

    // ************************************************************
    // Field layout of miscellaneous_control.
    // ************************************************************
    localparam int MISC_MA_ACK_BIT = 0;
    localparam logic [31:0] MISC_WRITE_MASK = 32'h00000001;

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [31:0] CFG_ADDR_RESET = 32'h00000000;
    localparam logic [31:0] CFG_DATA_RESET = 32'h00000000;
    localparam logic [31:0] INTERRUPT_ACK_VECTOR_RESET = 32'h00000000;
    localparam logic [31:0] MISC_RESET = 32'h00000000;

    // Read data returned when a configuration read is master-aborted.
    localparam logic [31:0] ABORT_READ_DATA = 32'hffffffff;

    // ************************************************************
    // PCI bus commands.
    // ************************************************************
    localparam logic [3:0] PCI_CMD_IACK = 4'h0;
    localparam logic [3:0] PCI_CMD_CFG_READ = 4'ha;
    localparam logic [3:0] PCI_CMD_CFG_WRITE = 4'hb;

    // Delayed transaction progress.
    typedef enum logic [1:0] {
        DT_IDLE,
        DT_ISSUE,
        DT_WAIT_PCI,
        DT_HOLD
    } dt_state_t;

endpackage

// File: rtl/pci_config_iack_generator.sv
module pci_config_iack_generator
    import cfg_iack_pkg::*;
(
    input wire logic core_clk_i,              // Core clock, 100 MHz.
    input wire logic rst_b_i,                 // Synchronous reset, active low.
    input wire logic qb_sel_i,                // Processor access strobe, one cycle.
    input wire logic qb_wr_i,                 // High for a write access.
    input wire logic [1:0] qb_reg_i,          // Register select.
    input wire logic [31:0] qb_wdata_i,       // Write data.
    output logic qb_ack_o,                    // Normal completion pulse.
    output logic qb_retry_o,                  // Retry pulse.
    output logic qb_berr_o,                   // Bus error pulse.
    output logic [31:0] qb_rdata_o,           // Read data, valid with qb_ack_o.
    output logic pci_req_o,                   // PCI cycle request pulse.
    output logic [3:0] pci_cmd_o,             // PCI command of the request.
    output logic [31:0] pci_addr_o,           // PCI address of the request.
    output logic [31:0] pci_wdata_o,          // PCI write data of the request.
    input wire logic pci_done_i,              // PCI cycle finished, one cycle.
    input wire logic pci_master_abort_i,      // Finished cycle was master-aborted.
    input wire logic [31:0] pci_rdata_i       // Data of the finished cycle.
);

    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Operation.
    // ************************************************************

    // The block takes one processor access per cycle and answers it one cycle later with
    // exactly one of ack, retry or bus error.
    // Local registers (config_cycle_address and miscellaneous_control) answer at once.
    // Accesses that need a PCI cycle run as delayed transactions in four steps:
    // idle, issue, wait for the PCI side, and hold the result.
    // The first attempt is latched and retried, and the PCI request follows a cycle later.
    // While the PCI cycle runs, every access is retried and changes nothing.
    // Once the PCI side reports the end, the result waits in hold for the repeated access.
    // The repeat is matched on direction and register select only, so software must not
    // move the configuration address between attempts; such writes are retried anyway
    // while a result is held.
    // Only one transaction is outstanding, and a master that never repeats its access
    // leaves the block in hold for good.

    // On the PCI side pci_req_o rises for one cycle with command, address and write data
    // already standing, and these fields stay put until the next delayed access is latched, a cycle before its request.
    // pci_done_i is taken only while waiting, so a stray end pulse at any other time is
    // ignored; the PCI side must run in this clock domain.

    // ************************************************************
    // State record.
    // ************************************************************
    typedef struct packed {
        // Delayed transaction step.
        dt_state_t dt;
        // Software-visible registers.
        logic [31:0] config_cycle_address;
        logic [31:0] config_cycle_data;
        logic [31:0] interrupt_ack_generator;
        logic [31:0] miscellaneous_control;
        // The latched access and how its PCI cycle ended.
        logic pend_wr;
        logic [1:0] pend_reg;
        logic pend_abort;
        // Processor bus answer.
        logic ack;
        logic retry;
        logic berr;
        logic [31:0] rdata;
        // PCI request and the fields that travel with it.
        logic req;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } gen_state_t;

    gen_state_t cur;
    gen_state_t next_cur;

    // ************************************************************
    // Helper functions.
    // ************************************************************

    // Builds the PCI configuration address from config_cycle_address.
    // Type 1 passes bus, device, function and register numbers on for a downstream bridge,
    // with the two low bits at 01.
    // Type 0 targets this bus: the device number becomes one select line from bit 16 up,
    // so only sixteen devices can be reached, and the two low bits are 00.
    // Bit 15 stays clear in both forms.
    function automatic logic [31:0] form_cfg_addr(input logic [31:0] ca);
        logic [31:0] a;
        logic [3:0] dev;
        a = 32'h00000000;
        dev = ca[CFG_DEV_MSB:CFG_DEV_LSB];
        if (ca[CFG_TYPE_BIT]) begin
            // Type 1 keeps the bus number so a downstream bridge can route it.
            a[CFG_BUS_MSB:CFG_BUS_LSB] = ca[CFG_BUS_MSB:CFG_BUS_LSB];
            a[CFG_DEV_MSB:CFG_DEV_LSB] = dev;
            a[CFG_FUNC_MSB:CFG_FUNC_LSB] = ca[CFG_FUNC_MSB:CFG_FUNC_LSB];
            a[CFG_REG_MSB:CFG_REG_LSB] = ca[CFG_REG_MSB:CFG_REG_LSB];
            a[1:0] = 2'h1;
        end else begin
            // Type 0 turns the device number into a one-hot select line.
            a[IDSEL_BASE_BIT + 32'(dev)] = 1'b1;
            a[CFG_FUNC_MSB:CFG_FUNC_LSB] = ca[CFG_FUNC_MSB:CFG_FUNC_LSB];
            a[CFG_REG_MSB:CFG_REG_LSB] = ca[CFG_REG_MSB:CFG_REG_LSB];
            a[1:0] = 2'h0;
        end
        return a;
    endfunction

    // True for accesses that must run as a delayed PCI transaction.
    // Generator writes stay local and are ignored.
    function automatic logic is_delayed(input logic wr, input logic [1:0] sel);
        return (sel == REG_SEL_CONFIG_DATA) || (sel == REG_SEL_IACK_GENERATOR && !wr);
    endfunction

    // ************************************************************
    // Next-state logic.
    // ************************************************************

    // Decodes processor accesses and walks the delayed transaction.
    // Answer and request strobes are cleared every cycle, so each one is a one-cycle pulse.
    // A master-abort on a configuration cycle ends as an ack when master_abort_acknowledge
    // is set and as a bus error otherwise, so software should keep that bit set while it
    // probes for devices.
    // Read data is zero for writes and bus errors and otherwise stands until the next answer.
    always_comb begin
        next_cur = cur;
        // Answer and request strobes last one cycle only.
        next_cur.ack = 1'b0;
        next_cur.retry = 1'b0;
        next_cur.berr = 1'b0;
        next_cur.req = 1'b0;

        case (cur.dt)
            DT_IDLE: begin
                if (qb_sel_i && is_delayed(qb_wr_i, qb_reg_i)) begin
                    // Latch the access, retry the master and queue the PCI cycle.
                    next_cur.pend_wr = qb_wr_i;
                    next_cur.pend_reg = qb_reg_i;
                    next_cur.pend_abort = 1'b0;
                    next_cur.retry = 1'b1;
                    next_cur.dt = DT_ISSUE;
                    if (qb_reg_i == REG_SEL_IACK_GENERATOR) begin
                        next_cur.cmd = PCI_CMD_IACK;
                        next_cur.addr = 32'h00000000;
                    end else if (qb_wr_i) begin
                        next_cur.config_cycle_data = qb_wdata_i;
                        next_cur.cmd = PCI_CMD_CFG_WRITE;
                        next_cur.addr = form_cfg_addr(cur.config_cycle_address);
                        next_cur.wdata = qb_wdata_i;
                    end else begin
                        next_cur.cmd = PCI_CMD_CFG_READ;
                        next_cur.addr = form_cfg_addr(cur.config_cycle_address);
                    end
                end else if (qb_sel_i) begin
                    // Local registers answer at once.
                    next_cur.ack = 1'b1;
                    next_cur.rdata = 32'h00000000;
                    case (qb_reg_i)
                        REG_SEL_CONFIG_ADDRESS: begin
                            if (qb_wr_i) begin
                                next_cur.config_cycle_address =
                                    qb_wdata_i & CFG_ADDR_WRITE_MASK;
                            end else begin
                                next_cur.rdata = cur.config_cycle_address;
                            end
                        end
                        REG_SEL_MISC_CONTROL: begin
                            if (qb_wr_i) begin
                                next_cur.miscellaneous_control =
                                    qb_wdata_i & MISC_WRITE_MASK;
                            end else begin
                                next_cur.rdata = cur.miscellaneous_control;
                            end
                        end
                        default: begin
                            // A write to the read-only generator is ignored.
                            next_cur.rdata = 32'h00000000;
                        end
                    endcase
                end
            end

            DT_ISSUE: begin
                // One request pulse per delayed transaction.
                next_cur.req = 1'b1;
                next_cur.dt = DT_WAIT_PCI;
                if (qb_sel_i) begin
                    next_cur.retry = 1'b1;
                end
            end

            DT_WAIT_PCI: begin
                // Every access is retried while the PCI cycle runs.
                if (qb_sel_i) begin
                    next_cur.retry = 1'b1;
                end
                if (pci_done_i) begin
                    // Keep the result and how the cycle ended until the repeat.
                    next_cur.pend_abort = pci_master_abort_i;
                    next_cur.dt = DT_HOLD;
                    if (cur.pend_reg == REG_SEL_IACK_GENERATOR) begin
                        next_cur.interrupt_ack_generator = pci_rdata_i;
                    end else if (!cur.pend_wr) begin
                        next_cur.config_cycle_data =
                            pci_master_abort_i ? ABORT_READ_DATA : pci_rdata_i;
                    end
                end
            end

            DT_HOLD: begin
                if (qb_sel_i && qb_wr_i == cur.pend_wr && qb_reg_i == cur.pend_reg) begin
                    // The repeated access collects the held result.
                    next_cur.dt = DT_IDLE;
                    next_cur.rdata = 32'h00000000;
                    if (cur.pend_reg == REG_SEL_IACK_GENERATOR) begin
                        // An aborted acknowledge cycle has no vector: always a bus error.
                        if (cur.pend_abort) begin
                            next_cur.berr = 1'b1;
                        end else begin
                            next_cur.ack = 1'b1;
                            next_cur.rdata = cur.interrupt_ack_generator;
                        end
                    end else if (cur.pend_abort &&
                                 !cur.miscellaneous_control[MISC_MA_ACK_BIT]) begin
                        // Aborted configuration cycle without master_abort_acknowledge.
                        next_cur.berr = 1'b1;
                    end else begin
                        next_cur.ack = 1'b1;
                        if (!cur.pend_wr) begin
                            next_cur.rdata = cur.config_cycle_data;
                        end
                    end
                end else if (qb_sel_i) begin
                    // Other accesses wait until the held result is taken.
                    next_cur.retry = 1'b1;
                end
            end

            default: begin
                next_cur.dt = DT_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State register.
    // ************************************************************

    // Registers the whole state record; reset gives a quiet idle block.
    // Reset clears every register, master_abort_acknowledge included, and drops any
    // half-finished delayed transaction without an answer.
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            cur.dt <= DT_IDLE;
            cur.config_cycle_address <= CFG_ADDR_RESET;
            cur.config_cycle_data <= CFG_DATA_RESET;
            cur.interrupt_ack_generator <= INTERRUPT_ACK_VECTOR_RESET;
            cur.miscellaneous_control <= MISC_RESET;
            cur.pend_wr <= 1'b0;
            cur.pend_reg <= REG_SEL_CONFIG_ADDRESS;
            cur.pend_abort <= 1'b0;
            cur.ack <= 1'b0;
            cur.retry <= 1'b0;
            cur.berr <= 1'b0;
            cur.rdata <= 32'h00000000;
            cur.req <= 1'b0;
            cur.cmd <= PCI_CMD_IACK;
            cur.addr <= 32'h00000000;
            cur.wdata <= 32'h00000000;
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************

    // Every output is a field of the registered state.
    // No logic stands between the flip-flops and the pins, so the far side sees clean edges.
    assign qb_ack_o = cur.ack;
    assign qb_retry_o = cur.retry;
    assign qb_berr_o = cur.berr;
    assign qb_rdata_o = cur.rdata;
    assign pci_req_o = cur.req;
    assign pci_cmd_o = cur.cmd;
    assign pci_addr_o = cur.addr;
    assign pci_wdata_o = cur.wdata;

endmodule

// File: testbench/cfg_iack_asserts.sv
module cfg_iack_asserts
    import cfg_iack_pkg::*;
(
    input wire logic core_clk_i,           // Core clock.
    input wire logic rst_b_i,              // Reset, active low.
    input wire logic qb_sel_i,             // Access strobe.
    input wire logic qb_wr_i,              // Write flag.
    input wire logic [1:0] qb_reg_i,       // Register select.
    input wire logic [31:0] qb_wdata_i,    // Write data.
    input wire logic qb_ack_o,             // Normal end.
    input wire logic qb_retry_o,           // Retry.
    input wire logic qb_berr_o,            // Bus error.
    input wire logic [31:0] qb_rdata_o,    // Read data.
    input wire logic pci_req_o,            // PCI request.
    input wire logic [3:0] pci_cmd_o,      // PCI command.
    input wire logic [31:0] pci_addr_o,    // PCI address.
    input wire logic [31:0] pci_wdata_o,   // PCI write data.
    input wire logic pci_done_i,           // PCI done.
    input wire logic pci_master_abort_i,   // PCI abort.
    input wire logic [31:0] pci_rdata_i    // PCI read data.
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Processor and PCI side checks.
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [2:0] ans;
    // Collect the three answer pulses into one vector.
    assign ans = {qb_berr_o, qb_retry_o, qb_ack_o};
    a_one_answer: assert property (qb_sel_i |=> $onehot(ans))
        else $error("access not answered by exactly one pulse");
    a_no_stray: assert property (!qb_sel_i |=> ans == 3'h0)
        else $error("answer without access");
    a_req_after_retry: assert property (pci_req_o |-> $past(qb_retry_o))
        else $error("PCI request without retry before it");
    a_req_from_sel: assert property (pci_req_o |-> $past(qb_sel_i, 2)
        && $past(qb_reg_i, 2) != REG_SEL_CONFIG_ADDRESS) else $error("request from no access");
    a_wr_cmd: assert property (pci_req_o |->
        (pci_cmd_o == PCI_CMD_CFG_WRITE) == $past(qb_wr_i, 2)) else $error("command direction");
    a_iack_addr: assert property (pci_req_o && pci_cmd_o == PCI_CMD_IACK |->
        pci_addr_o == 32'h0 && $past(qb_reg_i, 2) == REG_SEL_IACK_GENERATOR)
        else $error("acknowledge cycle wrong");
    a_addr_kind: assert property (pci_req_o && pci_cmd_o != PCI_CMD_IACK |->
        pci_addr_o[1] == 1'b0 && pci_cmd_o[3:1] == 3'h5) else $error("config cycle form");
    a_cmd_stable: assert property (pci_req_o |-> $stable(pci_cmd_o)
        && $stable(pci_addr_o) && $stable(pci_wdata_o)) else $error("request fields moved");
    a_rdata_hold: assert property (ans == 3'h0 |-> $stable(qb_rdata_o))
        else $error("read data changed without answer");
    c_berr: cover property (qb_berr_o);
    c_iack: cover property (pci_req_o && pci_cmd_o == PCI_CMD_IACK);
    c_abort_ack: cover property (qb_ack_o && qb_rdata_o == ABORT_READ_DATA);
endmodule

// File: testbench/pci_target_model.sv
module pci_target_model (
    input wire logic clk_i,            // Core clock.
    input wire logic req_i,            // Cycle request.
    input wire logic [3:0] wait_i,     // Extra cycles before the end.
    input wire logic abort_i,          // End the cycle by master-abort.
    input wire logic [31:0] data_i,    // Data to return.
    output logic done_o,               // Cycle end pulse.
    output logic master_abort_o,       // Abort qualifier.
    output logic [31:0] rdata_o        // Returned data.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] cnt = 5'h0;
    // Count down from the request and end the cycle once, never earlier.
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (req_i) begin
            cnt <= {1'b0, wait_i} + 5'h1;
        end else if (cnt > 5'h1) begin
            cnt <= cnt - 5'h1;
        end else if (cnt == 5'h1) begin
            cnt <= 5'h0;
            done_o <= 1'b1;
        end
    end
    // Outside the end pulse the lines show the inverse, so stale data never matches.
    assign rdata_o = done_o ? data_i : ~data_i;
    assign master_abort_o = done_o ? abort_i : ~abort_i;
endmodule

// File: testbench/tb_pci_config_iack_generator.sv
module tb_pci_config_iack_generator import cfg_iack_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] R_ACK = 3'h1;
    localparam logic [2:0] R_RTY = 3'h2;
    localparam logic [2:0] R_ERR = 3'h4;
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, qb_sel_i = 1'b0, qb_wr_i = 1'b0, pabort = 1'b0;
    logic [1:0] qb_reg_i = 2'h0;
    logic [3:0] pwait = 4'h0;
    logic [31:0] qb_wdata_i = 32'h0, pdata = 32'h0;
    logic qb_ack_o, qb_retry_o, qb_berr_o, pci_req_o, pci_done_i, pci_master_abort_i;
    logic [3:0] pci_cmd_o, s_cmd;
    logic [31:0] qb_rdata_o, pci_addr_o, pci_wdata_o, pci_rdata_i, s_addr, s_wd, rdv;
    logic [2:0] resp;
    int n_fail = 0, comparisons = 0, cyc = 0;
    pci_config_iack_generator pci_config_iack_generator_inst (.core_clk_i, .rst_b_i,
        .qb_sel_i, .qb_wr_i, .qb_reg_i, .qb_wdata_i, .qb_ack_o, .qb_retry_o, .qb_berr_o,
        .qb_rdata_o, .pci_req_o, .pci_cmd_o, .pci_addr_o, .pci_wdata_o, .pci_done_i,
        .pci_master_abort_i, .pci_rdata_i);
    pci_target_model pci_target_model_inst (.clk_i(core_clk_i), .req_i(pci_req_o),
        .wait_i(pwait), .abort_i(pabort), .data_i(pdata), .done_o(pci_done_i),
        .master_abort_o(pci_master_abort_i), .rdata_o(pci_rdata_i));
    // Free-running core clock.
    initial forever #5 core_clk_i = ~core_clk_i;
    // Capture each PCI request and cut a hang short.
    always @(posedge core_clk_i) begin
        cyc++;
        if (pci_req_o === 1'b1) begin
            s_cmd <= pci_cmd_o;
            s_addr <= pci_addr_o;
            s_wd <= pci_wdata_o;
        end
        if (cyc == 4000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask
    // One access: strobe for one cycle, then take the answer of the next cycle.
    task automatic acc(input logic w, input logic [1:0] r, input logic [31:0] d);
        @(posedge core_clk_i);
        #1;
        qb_sel_i = 1'b1;
        qb_wr_i = w;
        qb_reg_i = r;
        qb_wdata_i = d;
        @(posedge core_clk_i);
        #1;
        qb_sel_i = 1'b0;
        resp = {qb_berr_o, qb_retry_o, qb_ack_o};
        rdv = qb_rdata_o;
    endtask
    // Repeat an access while retried, up to n tries, then check the end.
    task automatic fin(input logic w, input logic [1:0] r, input logic [31:0] d,
            input logic [2:0] er, input logic [31:0] ed, input string nm, input int n);
        int i;
        i = 0;
        resp = R_RTY;
        while (resp === R_RTY && i < n) begin
            acc(w, r, d);
            i++;
        end
        chk({nm, " resp"}, {29'h0, er}, {29'h0, resp});
        if (er === R_ACK) chk({nm, " data"}, ed, rdv);
        $display("test %s done", nm);
    endtask
    // A delayed access must be retried at its first attempt.
    task automatic dly(input logic w, input logic [1:0] r, input logic [31:0] d,
            input logic [2:0] er, input logic [31:0] ed, input string nm);
        acc(w, r, d);
        chk({nm, " first"}, {29'h0, R_RTY}, {29'h0, resp});
        fin(w, r, d, er, ed, nm, 40);
    endtask
    // Main sequence of tests.
    initial begin
        repeat (3) @(posedge core_clk_i);
        #1;
        rst_b_i = 1'b1;
        fin(1'b0, REG_SEL_CONFIG_ADDRESS, 32'h0, R_ACK, CFG_ADDR_RESET, "addr rst", 1);
        fin(1'b0, REG_SEL_MISC_CONTROL, 32'h0, R_ACK, MISC_RESET, "misc rst", 1);
        fin(1'b1, REG_SEL_CONFIG_ADDRESS, '1, R_ACK, 32'h0, "addr wr", 1);
        fin(1'b0, 2'h0, 32'h0, R_ACK, CFG_ADDR_WRITE_MASK, "addr mask", 1);
        fin(1'b1, 2'h0, 32'h005a4dad, R_ACK, 32'h0, "set t1", 1);
        pwait = 4'h3;
        dly(1'b1, REG_SEL_CONFIG_DATA, 32'hc0ffee11, R_ACK, 32'h0, "cfg wr");
        chk("wr cmd", {28'h0, PCI_CMD_CFG_WRITE}, {28'h0, s_cmd});
        chk("wr data", 32'hc0ffee11, s_wd);
        chk("t1 addr", 32'h005a4dad, s_addr);
        fin(1'b1, 2'h0, {21'h3, 3'h2, 6'h10, 2'h0}, R_ACK, 32'h0, "set t0", 1);
        pdata = 32'h1234abcd;
        pwait = 4'h6;
        dly(1'b0, REG_SEL_CONFIG_DATA, 32'h0, R_ACK, pdata, "cfg rd");
        chk("rd cmd", {28'h0, PCI_CMD_CFG_READ}, {28'h0, s_cmd});
        chk("t0 addr", (32'h1 << (IDSEL_BASE_BIT + 3)) | 32'h240, s_addr);
        pabort = 1'b1;
        dly(1'b0, REG_SEL_CONFIG_DATA, 32'h0, R_ERR, 32'h0, "rd berr");
        fin(1'b1, REG_SEL_MISC_CONTROL, 32'hff, R_ACK, 32'h0, "misc set", 1);
        fin(1'b0, REG_SEL_MISC_CONTROL, 32'h0, R_ACK, MISC_WRITE_MASK, "misc rd", 1);
        dly(1'b0, REG_SEL_CONFIG_DATA, 32'h0, R_ACK, ABORT_READ_DATA, "rd ma");
        dly(1'b1, REG_SEL_CONFIG_DATA, 32'h5, R_ACK, 32'h0, "wr ma");
        pabort = 1'b0;
        pdata = 32'h000000a5;
        pwait = 4'h5;
        acc(1'b0, REG_SEL_IACK_GENERATOR, 32'h0);
        chk("iack first", {29'h0, R_RTY}, {29'h0, resp});
        repeat (20) @(posedge core_clk_i);
        acc(1'b0, REG_SEL_CONFIG_ADDRESS, 32'h0);
        chk("hold other", {29'h0, R_RTY}, {29'h0, resp});
        fin(1'b0, REG_SEL_IACK_GENERATOR, 32'h0, R_ACK, pdata, "iack", 40);
        chk("iack cmd", {28'h0, PCI_CMD_IACK}, {28'h0, s_cmd});
        chk("iack addr", 32'h0, s_addr);
        fin(1'b1, REG_SEL_IACK_GENERATOR, 32'h77, R_ACK, 32'h0, "iack wr", 1);
        pabort = 1'b1;
        dly(1'b0, REG_SEL_IACK_GENERATOR, 32'h0, R_ERR, 32'h0, "iack abort");
        give_verdict();
    end
endmodule
bind pci_config_iack_generator cfg_iack_asserts cfg_iack_asserts_inst (.core_clk_i,
    .rst_b_i, .qb_sel_i, .qb_wr_i, .qb_reg_i, .qb_wdata_i, .qb_ack_o, .qb_retry_o,
    .qb_berr_o, .qb_rdata_o, .pci_req_o, .pci_cmd_o, .pci_addr_o, .pci_wdata_o,
    .pci_done_i, .pci_master_abort_i, .pci_rdata_i);
